// file: core/sink_driver_pkg.sv
package sink_driver_pkg;

  // ==========================================================================
  // Geometry and timing
  // ==========================================================================
  localparam int CHANNEL_COUNT = 8;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] STORE_RESET = 8'h00;
  localparam logic [7:0] CHANNELS_OFF = 8'h00;
  localparam int FIFO_DEPTH = 32;
  localparam int SYNC_STAGES = 2;
  // Reference clock period in ps and the fastest cascade serial clock in MHz.
  localparam int REF_PERIOD_PS = 4000;
  localparam int SCLK_MAX_MHZ = 25;
  localparam int SCLK_MIN_PERIOD_PS = 1000000 / SCLK_MAX_MHZ;
  localparam int SCLK_MIN_PERIOD_CYC = SCLK_MIN_PERIOD_PS / REF_PERIOD_PS;
  localparam int TSD_TRIP_C = 150;

endpackage : sink_driver_pkg

// file: core/bit_fifo.sv
`timescale 1ns/100ps
// Small flip-flop FIFO between the serial front end and the shift stage.
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign wr_ready_out = (count_r != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_r != '0);
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem_r[rd_ptr_r];

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : bit_fifo

// file: core/serial_led_sink_driver.sv
`timescale 1ns/100ps
// Summary of operation
// - An eight-bit shift register feeds an eight-bit store, each stored bit gated by enable to one sink channel.
// - The serial output takes the last stage on the serial clock fall, ready for a downstream rising edge.
// - The store is transparent while the hold strobe is high and keeps its value while it is low.
// - A high output enable forces all eight channels off.
// - A low output enable lets each channel sink when its stored bit is one and stay off when it is zero.
// - Reset puts the shift and storage state into a known all-zero condition.
// - An overtemperature indication turns every sink channel off while it is asserted.
module serial_led_sink_driver #(
  parameter int CHANNELS = sink_driver_pkg::CHANNEL_COUNT,
  parameter int DEPTH = sink_driver_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic serial_data_in,
  input wire logic serial_clk_in,
  input wire logic hold_strobe_in,
  input wire logic output_disable_in,
  input wire logic overtemp_shutdown_in,
  output logic serial_data_out,
  output logic [CHANNELS-1:0] sink_channel_out,
  output logic overflow_out
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // The serial, strobe, disable and overtemperature pins are asynchronous to the reference clock, so each one passes two
  // flip-flops of its own before any logic reads it.
  logic data_meta_r;
  logic data_sync_r;
  logic sclk_meta_r;
  logic sclk_sync_r;
  logic strobe_meta_r;
  logic strobe_sync_r;
  logic disable_meta_r;
  logic disable_sync_r;
  logic overtemp_meta_r;
  logic overtemp_sync_r;
  logic sclk_prev_r;
  logic data_s;
  logic sclk_s;
  logic strobe_s;
  logic disable_s;
  logic overtemp_s;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_meta_r <= 1'b0;
      data_sync_r <= 1'b0;
    end else begin
      data_meta_r <= serial_data_in;
      data_sync_r <= data_meta_r;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_meta_r <= 1'b0;
      sclk_sync_r <= 1'b0;
    end else begin
      sclk_meta_r <= serial_clk_in;
      sclk_sync_r <= sclk_meta_r;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_meta_r <= 1'b0;
      strobe_sync_r <= 1'b0;
    end else begin
      strobe_meta_r <= hold_strobe_in;
      strobe_sync_r <= strobe_meta_r;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      disable_meta_r <= 1'b0;
      disable_sync_r <= 1'b0;
    end else begin
      disable_meta_r <= output_disable_in;
      disable_sync_r <= disable_meta_r;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      overtemp_meta_r <= 1'b0;
      overtemp_sync_r <= 1'b0;
    end else begin
      overtemp_meta_r <= overtemp_shutdown_in;
      overtemp_sync_r <= overtemp_meta_r;
    end
  end

  assign data_s = data_sync_r;
  assign sclk_s = sclk_sync_r;
  assign strobe_s = strobe_sync_r;
  assign disable_s = disable_sync_r;
  assign overtemp_s = overtemp_sync_r;

  // ==========================================================================
  // Serial clock edge detection
  // ==========================================================================
  // One test serves both directions, so a rise and a fall can never be
  // claimed for the same synchronised sample.
  function automatic logic level_moved(input logic now_v, input logic prev_v, input logic to_high);
    level_moved = (now_v == to_high) && (prev_v != to_high);
  endfunction : level_moved

  // The previous sample resets low, the idle level of the serial clock, so
  // no false rise follows reset.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  assign sclk_rise = level_moved(sclk_s, sclk_prev_r, 1'b1);
  assign sclk_fall = level_moved(sclk_s, sclk_prev_r, 1'b0);

  // ==========================================================================
  // Captured bits buffered ahead of the shift stage
  // ==========================================================================
  // The data line is sampled together with the clock so both saw the same
  // synchroniser delay; the FIFO drains one bit per cycle, so it fills only
  // if the shift stage is held off, and a lost bit is flagged on overflow.
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_bit;
  logic shift_go;
  logic overflow_r;

  bit_fifo #(
    .WIDTH(1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .wr_valid_in(sclk_rise),
    .wr_ready_out(fifo_ready),
    .wr_data_in(data_s),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(shift_go),
    .rd_data_out(fifo_bit)
  );

  // The shift stage stalls while a falling edge is being handled, so that
  // the serial output never sees a stage that moved in the same cycle.
  assign shift_go = fifo_valid && !sclk_fall;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      overflow_r <= 1'b0;
    end else if (sclk_rise && !fifo_ready) begin
      overflow_r <= 1'b1;
    end
  end

  assign overflow_out = overflow_r;

  // ==========================================================================
  // Shift register and serial output
  // ==========================================================================
  logic [CHANNELS-1:0] shift_r;
  logic sout_r;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_r <= sink_driver_pkg::SHIFT_RESET;
    end else if (shift_go) begin
      shift_r <= {shift_r[CHANNELS-2:0], fifo_bit};
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sout_r <= 1'b0;
    end else if (sclk_fall) begin
      sout_r <= shift_r[CHANNELS-1];
    end
  end

  assign serial_data_out = sout_r;

  // ==========================================================================
  // Storage stage and output gating
  // ==========================================================================
  logic [CHANNELS-1:0] store_r;
  logic [CHANNELS-1:0] chan_r;

  // Either shutdown source wins over whatever pattern the store holds.
  logic force_off;
  assign force_off = disable_s || overtemp_s;

  // Sampled transparency: while the strobe is high the store follows the
  // shift register each cycle, and it keeps the last value once it falls.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      store_r <= sink_driver_pkg::STORE_RESET;
    end else if (strobe_s) begin
      store_r <= shift_r;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan_r <= sink_driver_pkg::CHANNELS_OFF;
    end else if (force_off) begin
      chan_r <= sink_driver_pkg::CHANNELS_OFF;
    end else begin
      chan_r <= store_r;
    end
  end

  assign sink_channel_out = chan_r;

endmodule : serial_led_sink_driver

// file: bench/sink_driver_checker.sv
`timescale 1ns/100ps
module sink_driver_checker #(
  parameter int CHANNELS = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic serial_clk_in,
  input wire logic hold_strobe_in,
  input wire logic output_disable_in,
  input wire logic overtemp_shutdown_in,
  input wire logic serial_data_out,
  input wire logic [CHANNELS-1:0] sink_channel_out,
  input wire logic overflow_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence quiet_s;
    (!hold_strobe_in && !output_disable_in && !overtemp_shutdown_in)[*6];
  endsequence
  reset_clear_a: assert property ($fell(rst_in) |-> sink_channel_out == '0 && !serial_data_out)
    else $error("outputs not clear after reset");
  disable_off_a: assert property (output_disable_in[*6] |-> sink_channel_out == '0)
    else $error("channel on while disabled");
  overtemp_off_a: assert property (overtemp_shutdown_in[*6] |-> sink_channel_out == '0)
    else $error("channel on while overheated");
  any_off_a: assert property ((output_disable_in || overtemp_shutdown_in)[*6] |-> sink_channel_out == '0)
    else $error("gating lost");
  sout_fall_a: assert property ($changed(serial_data_out) |-> !serial_clk_in && !$past(serial_clk_in, 2))
    else $error("serial out moved outside a fall");
  sout_steady_a: assert property (serial_clk_in[*6] |-> $stable(serial_data_out))
    else $error("serial out moved while clock high");
  store_hold_a: assert property (quiet_s |-> $stable(sink_channel_out))
    else $error("store moved while strobe low");
  no_overflow_a: assert property (!overflow_out)
    else $error("bit buffer overflowed");
endmodule : sink_driver_checker
bind serial_led_sink_driver sink_driver_checker #(.CHANNELS(CHANNELS)) chk (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .serial_clk_in(serial_clk_in), .hold_strobe_in(hold_strobe_in),
  .output_disable_in(output_disable_in), .overtemp_shutdown_in(overtemp_shutdown_in),
  .serial_data_out(serial_data_out), .sink_channel_out(sink_channel_out), .overflow_out(overflow_out));

// file: bench/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model (
  input wire logic ref_clk_in,
  input wire logic cascade_in,
  output logic sclk_out,
  output logic sdata_out,
  output logic strobe_out
);
  logic [7:0] caught_r = 8'h00;
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    strobe_out = 1'b0;
  end
  // Twenty reference cycles a half period keeps the link well under the cascade limit.
  task automatic half();
    repeat (20) @(posedge ref_clk_in);
    #1;
  endtask : half
  // Farthest bit first; the downstream register is sampled on each rise.
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdata_out = b[i];
      half();
      sclk_out = 1'b1;
      caught_r = {caught_r[6:0], cascade_in};
      half();
      sclk_out = 1'b0;
    end
    sdata_out = ~sdata_out;
  endtask : send
  task automatic pulse();
    strobe_out = 1'b1;
    half();
    strobe_out = 1'b0;
  endtask : pulse
endmodule : serial_host_model

// file: bench/serial_led_sink_driver_bench.sv
`timescale 1ns/100ps
module serial_led_sink_driver_bench;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic dis = 1'b0;
  logic hot = 1'b0;
  logic sout;
  logic ovf;
  logic [7:0] sink;
  logic sclk;
  logic sdat;
  logic stb;
  int miscompares = 0;
  int samples_checked = 0;
  serial_led_sink_driver DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .serial_data_in(sdat),
    .serial_clk_in(sclk), .hold_strobe_in(stb), .output_disable_in(dis), .overtemp_shutdown_in(hot),
    .serial_data_out(sout), .sink_channel_out(sink), .overflow_out(ovf));
  serial_host_model host (.ref_clk_in(ref_clk_in), .cascade_in(sout), .sclk_out(sclk), .sdata_out(sdat),
    .strobe_out(stb));
  initial begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : cyc
  task automatic store_test();
    host.send(8'ha5);
    host.pulse();
    cyc(8);
    check(sink, 8'ha5);
    host.send(8'h3c);
    cyc(8);
    check(sink, 8'ha5);
    host.pulse();
    cyc(8);
    check(sink, 8'h3c);
  endtask : store_test
  task automatic cascade_test();
    host.send(8'h00);
    check(host.caught_r, 8'h3c);
    check(sink, 8'h3c);
  endtask : cascade_test
  task automatic gate_test();
    dis = 1'b1;
    cyc(8);
    check(sink, 8'h00);
    dis = 1'b0;
    hot = 1'b1;
    cyc(8);
    check(sink, 8'h00);
    hot = 1'b0;
    cyc(8);
    check(sink, 8'h3c);
  endtask : gate_test
  task automatic reset_test();
    host.send(8'h5a);
    rst_in = 1'b1;
    cyc(2);
    check({ovf, sout, sink[5:0]}, 8'h00);
    rst_in = 1'b0;
    cyc(3);
    check(sink, 8'h00);
    host.pulse();
    cyc(8);
    check(sink, 8'h00);
  endtask : reset_test
  initial begin
    cyc(6);
    rst_in = 1'b0;
    cyc(3);
    store_test();
    cascade_test();
    gate_test();
    reset_test();
    close_out();
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule : serial_led_sink_driver_bench
